// ==== fsc_host.sv ====
`timescale 1ns/1ps
`include "fsc_map.svh"
module fsc_host
  import fsc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // software register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // interrupt
  output logic irq,
  // device pins
  output logic [19:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n,
  output logic powerdown_reset_n,
  output logic vpp_enable,
  input wire logic ready_busy_out
);
  fsc_state_t state, next_state;
  fsc_op_t op, next_op;
  logic [1:0] ctrl, next_ctrl;
  logic [19:0] op_addr, next_op_addr;
  logic [7:0] op_wdata, next_op_wdata;
  logic [7:0] rd_byte, next_rd_byte;
  logic [7:0] dev_status, next_dev_status;
  logic array_mode, next_array_mode;
  logic vpp_lock, next_vpp_lock;
  logic [15:0] wait_cnt, next_wait_cnt;
  logic [15:0] wake_cnt, next_wake_cnt;
  logic [5:0] irq_stat, next_irq_stat, irq_en, next_irq_en, ev;
  logic cyc_start, cyc_wr, cyc_done;
  logic [19:0] cyc_addr;
  logic [7:0] cyc_wdata, cyc_rdata;
  logic reg_wr_cmd, read_ok, write_ok, pd_req;

  // ops that change array contents and so need the program voltage
  function automatic logic fsc_alters(input fsc_op_t o);
    fsc_alters = (o == FSC_OP_WRITE) || (o == FSC_OP_ERASE) || (o == FSC_OP_RESUME);
  endfunction

  // ops that end with a wait on ready/busy
  function automatic logic fsc_waits(input fsc_op_t o);
    fsc_waits = fsc_alters(o) || (o == FSC_OP_SUSPEND);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus cycle engine
  fsc_cycle u_cycle (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(cyc_start),
    .wr(cyc_wr),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_dq_in(flash_dq_in),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n)
  );

  assign pd_req = ctrl[`FSC_CTRL_PD_BIT];
  assign reg_wr_cmd = reg_wr && (reg_addr == `FSC_OFS_CMD);
  // reads and writes are refused until each wake delay has run out
  assign read_ok = (wake_cnt >= 16'(`FSC_WAKE_READ_CYC));
  assign write_ok = (wake_cnt >= 16'(`FSC_WAKE_WRITE_CYC));

  ////////////////////////////////////////////////////////////////////////
  // operation sequencer
  always_comb
  begin
    next_state = state;
    next_op = op;
    next_op_addr = op_addr;
    next_rd_byte = rd_byte;
    next_dev_status = dev_status;
    next_array_mode = array_mode;
    next_vpp_lock = vpp_lock;
    next_wait_cnt = wait_cnt;
    next_wake_cnt = wake_cnt;
    ev = 6'h00;
    cyc_start = 1'b0;
    cyc_wr = 1'b1;
    cyc_addr = op_addr;
    cyc_wdata = `FSC_CMD_READ_STATUS;
    if (state != FSC_ST_PD && wake_cnt != 16'hFFFF)
      next_wake_cnt = wake_cnt + 16'h1;
    case (state)
      FSC_ST_PD:
      begin
        // pins idle and reset low; the device ignores everything else
        next_wake_cnt = 16'h0000;
        next_dev_status = `FSC_SR_RESET;
        next_array_mode = 1'b1;
        if (!pd_req)
          next_state = FSC_ST_IDLE;
      end
      FSC_ST_IDLE:
      begin
        // a leftover settle count would keep the next bus cycle from starting
        next_wait_cnt = 16'h0000;
        if (pd_req)
          next_state = FSC_ST_PD;
        else if (reg_wr_cmd)
        begin
          next_op = fsc_op_t'(reg_wdata[2:0]);
          next_op_addr = op_addr;
          // alterations refused while a voltage error stands uncleared
          if (fsc_alters(fsc_op_t'(reg_wdata[2:0])) && vpp_lock)
            ev[`FSC_IRQ_REFUSED] = 1'b1;
          else if (reg_wdata[2:0] > 3'(FSC_OP_STATUS))
            ev[`FSC_IRQ_REFUSED] = 1'b1;
          else if (fsc_op_t'(reg_wdata[2:0]) == FSC_OP_READ ? !read_ok : !write_ok)
            ev[`FSC_IRQ_REFUSED] = 1'b1;
          else if (fsc_op_t'(reg_wdata[2:0]) == FSC_OP_READ && array_mode)
            next_state = FSC_ST_CYC2;
          else if (reg_wdata[2:0] inside {3'(FSC_OP_CLEAR), 3'(FSC_OP_SUSPEND),
                                          3'(FSC_OP_RESUME)})
            next_state = FSC_ST_CYC2;
          else
            next_state = FSC_ST_CYC1;
        end
      end
      FSC_ST_CYC1:
      begin
        // first write: a setup code, read-array or read-status
        cyc_start = 1'b1;
        case (op)
          FSC_OP_READ: cyc_wdata = `FSC_CMD_READ_ARRAY;
          FSC_OP_WRITE: cyc_wdata = `FSC_CMD_WRITE_SETUP;
          FSC_OP_ERASE: cyc_wdata = `FSC_CMD_ERASE_SETUP;
          default: cyc_wdata = `FSC_CMD_READ_STATUS;
        endcase
        if (cyc_done)
          next_state = FSC_ST_CYC2;
        cyc_start = (wait_cnt == 16'h0000);
        next_wait_cnt = cyc_done ? 16'h0000 : 16'h0001;
        if (cyc_done)
          next_array_mode = (op == FSC_OP_READ);
      end
      FSC_ST_CYC2:
      begin
        cyc_start = (wait_cnt == 16'h0000);
        next_wait_cnt = cyc_done ? 16'h0000 : 16'h0001;
        cyc_wr = !(op == FSC_OP_READ || op == FSC_OP_STATUS);
        case (op)
          FSC_OP_WRITE: cyc_wdata = op_wdata;
          // erase confirm always follows setup directly, never a stray code; resume sends confirm alone
          FSC_OP_ERASE: cyc_wdata = `FSC_CMD_CONFIRM;
          FSC_OP_RESUME: cyc_wdata = `FSC_CMD_CONFIRM;
          FSC_OP_CLEAR: cyc_wdata = `FSC_CMD_CLEAR_STATUS;
          FSC_OP_SUSPEND: cyc_wdata = `FSC_CMD_SUSPEND;
          default: cyc_wdata = `FSC_CMD_READ_STATUS;
        endcase
        if (cyc_done)
        begin
          // the device keeps this last command; our mode copy follows it
          if (cyc_wr)
            next_array_mode = 1'b0;
          if (op == FSC_OP_CLEAR)
            next_vpp_lock = 1'b0;
          if (!cyc_wr)
            next_rd_byte = cyc_rdata;
          if (op == FSC_OP_STATUS)
            next_dev_status = cyc_rdata;
          next_wait_cnt = 16'(`FSC_BUSY_ASSERT_CYC);
          if (fsc_waits(op))
            next_state = FSC_ST_SETTLE;
          else
          begin
            next_state = FSC_ST_IDLE;
            ev[`FSC_IRQ_DONE] = 1'b1;
          end
        end
      end
      FSC_ST_SETTLE:
      begin
        // ready/busy is only valid once the assert delay has passed
        if (pd_req)
        begin
          next_state = FSC_ST_PD;
          ev[`FSC_IRQ_ABORT] = 1'b1;
        end
        else if (wait_cnt <= 16'h0001)
          next_state = FSC_ST_POLL;
        else
          next_wait_cnt = wait_cnt - 16'h1;
      end
      FSC_ST_POLL:
      begin
        // the pin is always driven, so polling needs no select
        // suspend also ends here since the pin rises when suspended
        if (pd_req)
        begin
          next_state = FSC_ST_PD;
          ev[`FSC_IRQ_ABORT] = 1'b1;
        end
        else if (ready_busy_out)
        begin
          next_state = FSC_ST_STAT;
          next_wait_cnt = 16'h0000;
        end
      end
      FSC_ST_STAT:
      begin
        // the device answers reads with status while in status mode
        cyc_start = (wait_cnt == 16'h0000);
        cyc_wr = 1'b0;
        next_wait_cnt = cyc_done ? 16'h0000 : 16'h0001;
        if (cyc_done)
        begin
          next_dev_status = cyc_rdata;
          next_state = FSC_ST_IDLE;
          ev[`FSC_IRQ_DONE] = 1'b1;
          // missing program voltage and failures are reported
          ev[`FSC_IRQ_VPP] = cyc_rdata[`FSC_SR_VPP_BIT];
          ev[`FSC_IRQ_WERR] = cyc_rdata[`FSC_SR_WERR_BIT];
          ev[`FSC_IRQ_EERR] = cyc_rdata[`FSC_SR_EERR_BIT];
          if (cyc_rdata[`FSC_SR_VPP_BIT])
            next_vpp_lock = 1'b1;
        end
      end
      default: next_state = FSC_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers and interrupt; an event beats a clear in the same cycle
  always_comb
  begin
    next_ctrl = ctrl;
    next_op_wdata = op_wdata;
    next_irq_en = irq_en;
    next_irq_stat = irq_stat | ev;
    if (reg_wr)
    begin
      case (reg_addr)
        `FSC_OFS_CTRL: next_ctrl = reg_wdata[1:0];
        `FSC_OFS_WDATA: next_op_wdata = reg_wdata[7:0];
        `FSC_OFS_IRQ_EN: next_irq_en = reg_wdata[5:0];
        `FSC_OFS_IRQ_CLR: next_irq_stat = (irq_stat & ~reg_wdata[5:0]) | ev;
        default: next_ctrl = ctrl;
      endcase
    end
  end

  // address latch is kept apart so the sequencer never writes it
  logic [19:0] sw_addr;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      sw_addr <= 20'h00000;
    else if (reg_wr && reg_addr == `FSC_OFS_ADDR && state == FSC_ST_IDLE)
      sw_addr <= reg_wdata[19:0];
  end

  // read data stand in the cycle after the read strobe
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `FSC_OFS_CTRL: reg_rdata <= {30'h0, ctrl};
        `FSC_OFS_ADDR: reg_rdata <= {12'h000, sw_addr};
        `FSC_OFS_WDATA: reg_rdata <= {24'h000000, op_wdata};
        `FSC_OFS_STATE: reg_rdata <= {16'h0000, dev_status, 2'h0, write_ok, read_ok,
                                      vpp_lock, array_mode, state == FSC_ST_PD,
                                      state != FSC_ST_IDLE};
        `FSC_OFS_RDATA: reg_rdata <= {24'h000000, rd_byte};
        `FSC_OFS_IRQ_STAT: reg_rdata <= {26'h0, irq_stat};
        `FSC_OFS_IRQ_EN: reg_rdata <= {26'h0, irq_en};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
    else
      reg_rdata <= 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= FSC_ST_PD;
      op <= FSC_OP_READ;
      ctrl <= `FSC_CTRL_RESET;
      op_addr <= 20'h00000;
      op_wdata <= 8'h00;
      rd_byte <= 8'h00;
      dev_status <= `FSC_SR_RESET;
      array_mode <= 1'b1;
      vpp_lock <= 1'b0;
      wait_cnt <= 16'h0000;
      wake_cnt <= 16'h0000;
      irq_stat <= 6'h00;
      irq_en <= 6'h00;
      powerdown_reset_n <= 1'b0;
      vpp_enable <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      ctrl <= next_ctrl;
      op_addr <= (state == FSC_ST_IDLE) ? sw_addr : next_op_addr;
      op_wdata <= next_op_wdata;
      rd_byte <= next_rd_byte;
      dev_status <= next_dev_status;
      array_mode <= next_array_mode;
      vpp_lock <= next_vpp_lock;
      wait_cnt <= next_wait_cnt;
      wake_cnt <= next_wake_cnt;
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      // pulling the pin low mid-operation aborts it
      powerdown_reset_n <= (next_state != FSC_ST_PD);
      vpp_enable <= next_ctrl[`FSC_CTRL_VPP_BIT];
      irq <= |(next_irq_stat & next_irq_en);
    end
  end
endmodule // fsc_host

// ==== fsc_map.svh ====
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

// software register offsets (byte addresses)
`define FSC_OFS_CTRL 8'h00
`define FSC_OFS_ADDR 8'h04
`define FSC_OFS_WDATA 8'h08
`define FSC_OFS_CMD 8'h0C
`define FSC_OFS_STATE 8'h10
`define FSC_OFS_RDATA 8'h14
`define FSC_OFS_IRQ_STAT 8'h18
`define FSC_OFS_IRQ_CLR 8'h1C
`define FSC_OFS_IRQ_EN 8'h20

// control register fields and reset value
`define FSC_CTRL_PD_BIT 0
`define FSC_CTRL_VPP_BIT 1
`define FSC_CTRL_RESET 2'h1

// interrupt bit positions
`define FSC_IRQ_DONE 0
`define FSC_IRQ_VPP 1
`define FSC_IRQ_WERR 2
`define FSC_IRQ_EERR 3
`define FSC_IRQ_ABORT 4
`define FSC_IRQ_REFUSED 5
`define FSC_IRQ_W 6

// device status byte fields
`define FSC_SR_READY_BIT 7
`define FSC_SR_EERR_BIT 5
`define FSC_SR_WERR_BIT 4
`define FSC_SR_VPP_BIT 3
`define FSC_SR_RESET 8'h80

// device command bytes
`define FSC_CMD_READ_ARRAY 8'hFF
`define FSC_CMD_READ_STATUS 8'h70
`define FSC_CMD_CLEAR_STATUS 8'h50
`define FSC_CMD_WRITE_SETUP 8'h40
`define FSC_CMD_ERASE_SETUP 8'h20
`define FSC_CMD_CONFIRM 8'hD0
`define FSC_CMD_SUSPEND 8'hB0

// timing, in ns and in cycles of the 125 MHz clock (least times round up)
`define FSC_CLK_MHZ 125
`define FSC_T_SETUP_NS 20
`define FSC_T_STROBE_NS 120
`define FSC_T_HOLD_NS 20
`define FSC_T_BUSY_ASSERT_NS 200
`define FSC_T_WAKE_READ_NS 400
`define FSC_T_WAKE_WRITE_NS 1000
`define FSC_CYC(ns) (((ns) * `FSC_CLK_MHZ + 999) / 1000)
`define FSC_SETUP_CYC `FSC_CYC(`FSC_T_SETUP_NS)
`define FSC_STROBE_CYC `FSC_CYC(`FSC_T_STROBE_NS)
`define FSC_HOLD_CYC `FSC_CYC(`FSC_T_HOLD_NS)
`define FSC_BUSY_ASSERT_CYC `FSC_CYC(`FSC_T_BUSY_ASSERT_NS)
`define FSC_WAKE_READ_CYC `FSC_CYC(`FSC_T_WAKE_READ_NS)
`define FSC_WAKE_WRITE_CYC `FSC_CYC(`FSC_T_WAKE_WRITE_NS)

`endif

// ==== fsc_pkg.sv ====
package fsc_pkg;
  typedef enum logic [2:0] {
    FSC_OP_READ,
    FSC_OP_WRITE,
    FSC_OP_ERASE,
    FSC_OP_CLEAR,
    FSC_OP_SUSPEND,
    FSC_OP_RESUME,
    FSC_OP_STATUS
  } fsc_op_t;
  typedef enum {
    FSC_ST_PD,
    FSC_ST_IDLE,
    FSC_ST_CYC1,
    FSC_ST_CYC2,
    FSC_ST_SETTLE,
    FSC_ST_POLL,
    FSC_ST_STAT
  } fsc_state_t;
  typedef enum {
    FSC_CY_IDLE,
    FSC_CY_SETUP,
    FSC_CY_STROBE,
    FSC_CY_HOLD
  } fsc_cyc_t;
endpackage

// ==== fsc_cycle.sv ====
`timescale 1ns/1ps
`include "fsc_map.svh"
module fsc_cycle
  import fsc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request from the sequencer
  input wire logic start,
  input wire logic wr,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  // device bus pins
  output logic [19:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n
);
  fsc_cyc_t phase, next_phase;
  logic [3:0] cnt, next_cnt;
  logic is_wr, next_is_wr;
  logic [19:0] next_addr;
  logic [7:0] next_dq_out, next_rdata;

  ////////////////////////////////////////////////////////////////////////
  // one bus cycle: setup, strobe, hold; chip select spans the whole cycle
  always_comb
  begin
    next_phase = phase;
    next_cnt = cnt;
    next_is_wr = is_wr;
    next_addr = flash_addr;
    next_dq_out = flash_dq_out;
    next_rdata = rdata;
    done = 1'b0;
    case (phase)
      FSC_CY_IDLE:
      begin
        if (start)
        begin
          next_phase = FSC_CY_SETUP;
          next_cnt = 4'(`FSC_SETUP_CYC - 1);
          next_is_wr = wr;
          next_addr = addr;
          next_dq_out = wdata;
        end
      end
      FSC_CY_SETUP:
      begin
        if (cnt == 4'h0)
        begin
          next_phase = FSC_CY_STROBE;
          next_cnt = 4'(`FSC_STROBE_CYC - 1);
        end
        else
          next_cnt = cnt - 4'h1;
      end
      FSC_CY_STROBE:
      begin
        if (cnt == 4'h0)
        begin
          next_phase = FSC_CY_HOLD;
          next_cnt = 4'(`FSC_HOLD_CYC - 1);
          if (!is_wr)
            next_rdata = flash_dq_in; // sampled at the end of the access time
        end
        else
          next_cnt = cnt - 4'h1;
      end
      FSC_CY_HOLD:
      begin
        if (cnt == 4'h0)
        begin
          next_phase = FSC_CY_IDLE;
          done = 1'b1;
        end
        else
          next_cnt = cnt - 4'h1;
      end
      default: next_phase = FSC_CY_IDLE;
    endcase
  end

  // pins come from flops so no glitch reaches the device strobes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      phase <= FSC_CY_IDLE;
      cnt <= 4'h0;
      is_wr <= 1'b0;
      flash_addr <= 20'h00000;
      flash_dq_out <= 8'h00;
      rdata <= 8'h00;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_oe_n <= 1'b1;
    end
    else
    begin
      phase <= next_phase;
      cnt <= next_cnt;
      is_wr <= next_is_wr;
      flash_addr <= next_addr;
      flash_dq_out <= next_dq_out;
      rdata <= next_rdata;
      flash_ce_n <= (next_phase == FSC_CY_IDLE);
      // write enable only ever falls inside the chip-select window
      flash_we_n <= !(next_phase == FSC_CY_STROBE && next_is_wr);
      flash_oe_n <= !(next_phase == FSC_CY_STROBE && !next_is_wr);
      flash_dq_oe_n <= !(next_phase != FSC_CY_IDLE && next_is_wr);
    end
  end
endmodule // fsc_cycle

// ==== fsc_props.sv ====
`timescale 1ns/1ps
module fsc_props
  import fsc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  // device pins
  input wire logic [19:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [7:0] flash_dq_in,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic powerdown_reset_n,
  input wire logic vpp_enable,
  input wire logic ready_busy_out
);
  logic [7:0] wake_cnt;
  logic [7:0] next_wake_cnt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////
  // cycles since the device left powerdown, saturating so it never wraps
  always_comb
  begin
    next_wake_cnt = (wake_cnt == 8'hFF) ? wake_cnt : wake_cnt + 8'h1;
    if (rst || !powerdown_reset_n)
      next_wake_cnt = 8'h0;
  end

  always_ff @(posedge clk_sys)
  begin
    wake_cnt <= next_wake_cnt;
  end

  // strobe phase of a write: 15 low cycles with the data held
  sequence s_we_strobe;
    (!flash_we_n)[*7] ##1 (!flash_we_n && $stable(flash_dq_out))[*8] ##1 flash_we_n;
  endsequence

  // hold phase: select and data drive stay 3 cycles, then select lifts
  sequence s_we_hold;
    (!flash_ce_n && !flash_dq_oe_n)[*3] ##1 flash_ce_n;
  endsequence

  a_write_gated: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe outside a selected write cycle");
  a_no_contention: assert property (!flash_oe_n |-> flash_dq_oe_n && flash_we_n)
    else $error("controller drives data during a read");
  a_pd_quiet: assert property (!powerdown_reset_n |-> flash_ce_n && flash_we_n && flash_oe_n)
    else $error("bus activity while device powered down");
  a_wake_write: assert property (!flash_we_n |-> wake_cnt >= 8'd125)
    else $error("write enable too soon after wake");
  a_wake_read: assert property (!flash_oe_n |-> wake_cnt >= 8'd50)
    else $error("read too soon after wake");
  a_we_setup: assert property ($fell(flash_we_n) |-> $past(!flash_ce_n, 3) && !flash_dq_oe_n)
    else $error("write strobe without setup time");
  a_we_strobe: assert property ($fell(flash_we_n) |-> s_we_strobe)
    else $error("write strobe length or data wrong");
  a_we_hold: assert property ($rose(flash_we_n) |-> s_we_hold)
    else $error("write hold phase wrong");
  a_oe_strobe: assert property ($fell(flash_oe_n) |->
    (!flash_oe_n)[*8] ##1 (!flash_oe_n)[*7] ##1 flash_oe_n)
    else $error("read strobe length wrong");
endmodule // fsc_props

// ==== fsc_flash_model.sv ====
`timescale 1ns/1ps
module fsc_flash_model
  import fsc_pkg::*;
(
  // sampling clock
  input wire logic clk_sys,
  // device pins
  input wire logic [19:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [7:0] host_dq,
  output logic [7:0] dev_dq,
  input wire logic powerdown_reset_n,
  input wire logic vpp_enable,
  output logic ready_busy_out,
  // scenario control: every algorithm that ends while this is high fails verify
  input wire logic fail_en
);
  localparam int BUSY_DLY = 24;
  localparam int BUSY_LEN = 200;
  logic [7:0] mem [0:15];
  logic [7:0] sr, last_dq, tdata;
  logic status_mode, busy, susp, is_erase, we_q;
  logic [1:0] pend;
  logic [3:0] tgt;
  int cnt;

  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = 8'hFF;
  end

  ////////////////////////////////////////////////////////////
  // busy pin is always driven, high in suspend and powerdown
  assign ready_busy_out = !(busy && !susp && cnt >= BUSY_DLY);
  // an unread bus floats: show the inverse of the last byte, not a stale copy
  assign dev_dq = (!flash_ce_n && !flash_oe_n && powerdown_reset_n) ?
    (status_mode ? sr : mem[flash_addr[3:0]]) : ~last_dq;

  always @(posedge clk_sys)
  begin
    we_q <= flash_we_n;
    if (!flash_ce_n && !flash_oe_n)
      last_dq <= dev_dq;
    if (!powerdown_reset_n)
    begin
      // powerdown aborts, resets status and ignores every other pin
      sr <= 8'h80;
      status_mode <= 1'b0;
      pend <= 2'd0;
      busy <= 1'b0;
      susp <= 1'b0;
    end
    else
    begin
      if (busy && !susp)
        cnt <= cnt + 1;
      if (busy && cnt == BUSY_LEN)
      begin
        busy <= 1'b0;
        sr[7] <= 1'b1;
        if (fail_en)
          sr[is_erase ? 5 : 4] <= 1'b1;
        else if (is_erase)
          mem <= '{default: 8'hFF};
        else
          mem[tgt] <= mem[tgt] & tdata;
      end
      // command taken on the rising write enable with select low
      if (flash_we_n && !we_q && !flash_ce_n)
      begin
        pend <= 2'd0;
        status_mode <= 1'b1;
        if (pend == 2'd2 && host_dq != 8'hD0)
          sr[5:4] <= 2'b11;
        else if (pend != 2'd0 && (!vpp_enable || sr[3]))
          sr[3] <= 1'b1;
        else if (pend != 2'd0)
        begin
          // only a write setup then its data byte, or an erase setup then confirm, starts an alteration
          busy <= 1'b1;
          cnt <= 0;
          sr[7] <= 1'b0;
          is_erase <= (pend == 2'd2);
          tgt <= flash_addr[3:0];
          tdata <= host_dq;
        end
        else
        begin
          case (host_dq)
            8'hFF: status_mode <= 1'b0;
            8'h50: sr[5:3] <= 3'b000;
            8'h40: pend <= 2'd1;
            8'h20: pend <= 2'd2;
            8'hB0: susp <= busy;
            8'hD0: susp <= 1'b0;
            default: ;
          endcase
        end
      end
    end
  end
endmodule // fsc_flash_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "fsc_map.svh"
module tb_top;
  localparam logic [31:0] DONE = 32'h1 << `FSC_IRQ_DONE;
  localparam logic [31:0] VPPE = 32'h1 << `FSC_IRQ_VPP;
  localparam logic [31:0] WERR = 32'h1 << `FSC_IRQ_WERR;
  localparam logic [31:0] EERR = 32'h1 << `FSC_IRQ_EERR;
  localparam logic [31:0] ABRT = 32'h1 << `FSC_IRQ_ABORT;
  localparam logic [31:0] REFU = 32'h1 << `FSC_IRQ_REFUSED;
  logic clk_sys, rst, reg_wr, reg_rd, irq, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n;
  logic powerdown_reset_n, vpp_enable, ready_busy_out, fail_en, saw_busy;
  logic [7:0] reg_addr, flash_dq_in, flash_dq_out;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [19:0] flash_addr;
  int n_errors = 0;
  int compares = 0;

  fsc_host dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n), .powerdown_reset_n(powerdown_reset_n),
    .vpp_enable(vpp_enable), .ready_busy_out(ready_busy_out));
  fsc_flash_model u_dev (.clk_sys(clk_sys), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .host_dq(flash_dq_out),
    .dev_dq(flash_dq_in), .powerdown_reset_n(powerdown_reset_n), .vpp_enable(vpp_enable),
    .ready_busy_out(ready_busy_out), .fail_en(fail_en));

  ////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask

  task automatic wait_irq();
    int k;
    saw_busy = 1'b0;
    for (k = 0; k < 3000 && irq !== 1'b1; k++)
    begin
      @(posedge clk_sys);
      if (ready_busy_out === 1'b0)
        saw_busy = 1'b1;
    end
    chk("irq raised", 32'(irq), 32'h1);
  endtask

  // one operation: issue, wait, compare the event bits, clear them
  task automatic op(input logic [2:0] code, input logic [31:0] exp_stat);
    wr(`FSC_OFS_CMD, {29'h0, code});
    wait_irq();
    rd(`FSC_OFS_IRQ_STAT);
    chk("irq status", rv, exp_stat);
    wr(`FSC_OFS_IRQ_CLR, 32'h3F);
  endtask

  task automatic wake();
    wr(`FSC_OFS_CTRL, 32'h2);
    repeat (130) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`FSC_OFS_STATE);
    chk("state powered down", rv & 32'h2, 32'h2);
    chk("busy pin in powerdown", 32'(ready_busy_out), 32'h1);
    chk("pins quiet", 32'({powerdown_reset_n, flash_ce_n, flash_we_n}), 32'h3);
    rd(`FSC_OFS_IRQ_STAT);
    chk("irq status at reset", rv, 32'h0);
    rd(8'h3C);
    chk("unmapped read", rv, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_write_read();
    wr(`FSC_OFS_IRQ_EN, 32'h3F);
    wake();
    wr(`FSC_OFS_ADDR, 32'h5);
    wr(`FSC_OFS_WDATA, 32'hA5);
    op(3'd1, DONE);
    chk("busy pin dropped", 32'(saw_busy), 32'h1);
    chk("byte programmed", 32'(u_dev.mem[5]), 32'hA5);
    rd(`FSC_OFS_STATE);
    chk("status byte", 32'(rv[15:8]), 32'h80);
    op(3'd0, DONE);
    rd(`FSC_OFS_RDATA);
    chk("array byte", rv & 32'hFF, 32'hA5);
    chk("irq after clear", 32'(irq), 32'h0);
    $display("t_write_read done");
  endtask

  // error flags stay set in the device until a clear-status command
  task automatic t_errors();
    fail_en <= 1'b1;
    op(3'd2, DONE | EERR);
    op(3'd1, DONE | WERR | EERR);
    fail_en <= 1'b0;
    op(3'd3, DONE);
    chk("byte kept on failed ops", 32'(u_dev.mem[5]), 32'hA5);
    wr(`FSC_OFS_CTRL, 32'h0);
    op(3'd1, DONE | VPPE);
    wr(`FSC_OFS_CTRL, 32'h2);
    op(3'd1, REFU);
    op(3'd3, DONE);
    op(3'd1, DONE);
    $display("t_errors done");
  endtask

  task automatic t_abort();
    int k;
    wr(`FSC_OFS_CMD, 32'h2);
    for (k = 0; k < 300 && ready_busy_out !== 1'b0; k++)
      @(posedge clk_sys);
    wr(`FSC_OFS_CTRL, 32'h3);
    wait_irq();
    rd(`FSC_OFS_IRQ_STAT);
    chk("abort flagged", rv & ABRT, ABRT);
    wr(`FSC_OFS_IRQ_CLR, 32'h3F);
    chk("busy pin in powerdown", 32'(ready_busy_out), 32'h1);
    chk("block not erased", 32'(u_dev.mem[5]), 32'hA5);
    wake();
    op(3'd6, DONE);
    rd(`FSC_OFS_STATE);
    chk("status after powerdown", 32'(rv[15:8]), 32'h80);
    op(3'd0, DONE);
    rd(`FSC_OFS_RDATA);
    chk("array after wake", rv & 32'hFF, 32'hA5);
    $display("t_abort done");
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fail_en = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_write_read();
    t_errors();
    t_abort();
    print_verdict();
  end

  // watchdog: the whole sequence needs well under 15000 cycles
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end
endmodule // tb_top

bind fsc_host fsc_props u_props (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_n(flash_dq_oe_n), .powerdown_reset_n(powerdown_reset_n),
  .vpp_enable(vpp_enable), .ready_busy_out(ready_busy_out));
